// >>> shared/scs_pkg.sv
// package for the system clock select and tuning block
// assumes a single 25 MHz register clock; oscillators are modelled as enables
package scs_pkg;
    // register byte addresses on the axi4-lite slave
    localparam logic [3:0] OSC_CONTROL_ADDR = 4'h0;
    localparam logic [3:0] OSC_TUNING_ADDR = 4'h4;
    localparam logic [3:0] SLEEP_CTRL_ADDR = 4'h8;
    localparam logic [3:0] CLOCK_STATUS_ADDR = 4'hC;
    // field positions, oscillator control
    localparam int IDLE_BIT = 7;
    localparam int FREQ_HI = 6;
    localparam int FREQ_LO = 4;
    localparam int STARTUP_BIT = 3;
    localparam int STABLE_BIT = 2;
    localparam int SEL_HI = 1;
    localparam int SEL_LO = 0;
    // field positions, oscillator tuning
    localparam int LFSRC_BIT = 7;
    localparam int MULT_BIT = 6;
    localparam int TRIM_HI = 5;
    // reset values
    localparam logic [2:0] FREQ_RESET = 3'h4;
    localparam logic [5:0] TRIM_RESET = 6'h00;
    // clock select codes
    localparam logic [1:0] SEL_DEFAULT = 2'h0;
    localparam logic [1:0] SEL_SECONDARY = 2'h1;
    localparam logic [1:0] SEL_PRIMARY = 2'h2;
    localparam logic [1:0] SEL_INTERNAL = 2'h3;
    // oscillator mode configuration codes
    localparam logic [2:0] MODE_EXT_MULT = 3'h6;
    localparam logic [2:0] MODE_XTAL_MULT = 3'h4;
    // fast rc divide for the derived low-frequency clock
    localparam int LF_DIV = 256;
    // switch pause: two old-source cycles plus four new-source cycles
    localparam int OLD_CYCLES = 2;
    localparam int NEW_CYCLES = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SRC_PRIMARY,
        SRC_SECONDARY,
        SRC_FAST_RC,
        SRC_LOW_RC
    } scs_src_t;

    typedef struct packed {
        logic [2:0] osc_mode;
        logic default_source_config_bit;
        logic two_speed_startup_config;
    } scs_config_t;

    typedef struct packed {
        logic secondary_osc_enable;
        logic startup_timer_done;
        logic fast_rc_stable;
    } scs_osc_stat_t;
endpackage : scs_pkg

// >>> rtl/scs_clock_select.sv
// system clock source selection, internal oscillator control and tuning
// assumes oscillator status inputs come from other clock domains; each is synchronised
`timescale 1ns/1ps
`default_nettype none

module scs_clock_select
    import scs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire scs_config_t cfg,
    input wire scs_osc_stat_t osc_stat,
    input wire logic sleep_exec,
    output var scs_src_t active_source,
    output logic [2:0] fast_rc_div_sel,
    output logic [5:0] fast_rc_trim,
    output logic low_freq_source_select,
    output logic multiplier_on,
    output logic clock_paused,
    output logic secondary_running,
    output logic idle_mode,
    output logic sleep_mode,
    output logic watchdog_clk_from_low_rc
);

    // ************************************************************
    // input synchronisers
    // ************************************************************
    // only the second stage is read; the first may still be settling
    scs_osc_stat_t stat_meta_q;
    scs_osc_stat_t stat_q;
    always_ff @(posedge aclk) begin
        stat_meta_q <= osc_stat;
        stat_q <= stat_meta_q;
    end

    // ************************************************************
    // axi4-lite write channel
    // ************************************************************
    logic [3:0] awaddr_q;
    logic aw_held_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_held_q;
    logic wr_fire;
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = !w_held_q && !s_axi_bvalid;
    assign wr_fire = aw_held_q && w_held_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
            end
        end
    end

    logic wr_ctrl;
    logic wr_tune;
    logic wr_known;
    assign wr_ctrl = wr_fire && awaddr_q == OSC_CONTROL_ADDR && wstrb_q[0];
    assign wr_tune = wr_fire && awaddr_q == OSC_TUNING_ADDR && wstrb_q[0];
    assign wr_known = awaddr_q == OSC_CONTROL_ADDR || awaddr_q == OSC_TUNING_ADDR
        || awaddr_q == SLEEP_CTRL_ADDR || awaddr_q == CLOCK_STATUS_ADDR;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ************************************************************
    // control registers
    // ************************************************************
    logic idle_sel_q;
    logic [2:0] freq_q;
    logic [1:0] sel_q;
    logic lfsrc_q;
    logic mult_q;
    logic [5:0] trim_q;
    logic mult_mode;
    assign mult_mode = cfg.osc_mode == MODE_EXT_MULT || cfg.osc_mode == MODE_XTAL_MULT;

    // sync reset clears select on every reset form
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_sel_q <= 1'b0;
            freq_q <= FREQ_RESET;
            sel_q <= SEL_DEFAULT;
        end else if (wr_ctrl) begin
            idle_sel_q <= wdata_q[IDLE_BIT];
            freq_q <= wdata_q[FREQ_HI:FREQ_LO];
            sel_q <= wdata_q[SEL_HI:SEL_LO];
        end
    end

    // checked without the disable so the reset cycles themselves count
    a_select_reset: assert property (@(posedge aclk)
        !aresetn |=> sel_q == SEL_DEFAULT && freq_q == FREQ_RESET && !idle_sel_q)
        else $error("control fields not reset");
    a_trim_write: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_tune |=> fast_rc_trim == $past(wdata_q[TRIM_HI:0]))
        else $error("trim not applied");

    // mode pins may leave a multiplied mode at any time; the bit then drops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lfsrc_q <= 1'b0;
            mult_q <= 1'b0;
            trim_q <= TRIM_RESET;
        end else begin
            if (wr_tune) begin
                lfsrc_q <= wdata_q[LFSRC_BIT];
                trim_q <= wdata_q[TRIM_HI:0];
                mult_q <= mult_mode && wdata_q[MULT_BIT];
            end else if (!mult_mode) begin
                mult_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // source selection and glitch-free switch
    // ************************************************************
    scs_src_t target_src;
    always_comb begin
        case (sel_q)
            SEL_INTERNAL: target_src = SRC_FAST_RC;
            SEL_PRIMARY: target_src = SRC_PRIMARY;
            SEL_SECONDARY: target_src = SRC_SECONDARY;
            default: target_src = cfg.default_source_config_bit ? SRC_PRIMARY : SRC_FAST_RC;
        endcase
        // lowest frequency code picks a low-frequency source
        if (target_src == SRC_FAST_RC && freq_q == 3'h0 && !lfsrc_q) begin
            target_src = SRC_LOW_RC;
        end
    end

    typedef enum logic [1:0] {
        SW_RUN,
        SW_OLD,
        SW_NEW
    } scs_sw_t;
    scs_sw_t sw_q;
    logic [2:0] sw_cnt_q;
    scs_src_t pending_q;

    // the old clock is counted then the new; no clock runs stopped in between
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sw_q <= SW_RUN;
            sw_cnt_q <= 3'h0;
            active_source <= SRC_PRIMARY;
            pending_q <= SRC_PRIMARY;
        end else begin
            case (sw_q)
                SW_RUN: begin
                    if (target_src != active_source) begin
                        sw_q <= SW_OLD;
                        pending_q <= target_src;
                        sw_cnt_q <= 3'(OLD_CYCLES - 1);
                    end
                end
                SW_OLD: begin
                    if (sw_cnt_q == 3'h0) begin
                        sw_q <= SW_NEW;
                        sw_cnt_q <= 3'(NEW_CYCLES - 1);
                    end else begin
                        sw_cnt_q <= sw_cnt_q - 3'h1;
                    end
                end
                SW_NEW: begin
                    if (sw_cnt_q == 3'h0) begin
                        sw_q <= SW_RUN;
                        active_source <= pending_q;
                    end else begin
                        sw_cnt_q <= sw_cnt_q - 3'h1;
                    end
                end
                default: sw_q <= SW_RUN;
            endcase
        end
    end
    assign clock_paused = sw_q != SW_RUN;

    // the old source stays in charge until the new one is counted in
    a_source_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        clock_paused |-> $stable(active_source))
        else $error("source changed during pause");
    a_switch_start: assert property (@(posedge aclk) disable iff (!aresetn)
        (sw_q == SW_RUN && target_src != active_source) |=> sw_q == SW_OLD
        && pending_q == $past(target_src)) else $error("switch not started");

    // ************************************************************
    // sleep handling and status
    // ************************************************************
    logic sleep_secondary_bad;
    assign sleep_secondary_bad = sel_q == SEL_SECONDARY && !stat_q.secondary_osc_enable;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_mode <= 1'b0;
            sleep_mode <= 1'b0;
        end else if (sleep_exec && !sleep_secondary_bad) begin
            idle_mode <= idle_sel_q;
            sleep_mode <= !idle_sel_q;
        end else if (!sleep_exec) begin
            idle_mode <= 1'b0;
            sleep_mode <= 1'b0;
        end
    end

    // a refused sleep leaves both mode flags as they were
    a_sleep_entry: assert property (@(posedge aclk) disable iff (!aresetn)
        sleep_exec && !sleep_secondary_bad |=> idle_mode == $past(idle_sel_q)
        && sleep_mode != $past(idle_sel_q)) else $error("sleep mode not entered");
    a_sleep_refused: assert property (@(posedge aclk) disable iff (!aresetn)
        sleep_exec && sleep_secondary_bad |=> $stable(idle_mode) && $stable(sleep_mode))
        else $error("refused sleep changed mode");
    a_sleep_release: assert property (@(posedge aclk) disable iff (!aresetn)
        !sleep_exec |=> !idle_mode && !sleep_mode)
        else $error("mode flags stuck");

    logic startup_bit;
    logic stable_bit;
    // two-speed config picks the startup bit's reset-time view
    assign startup_bit = active_source == SRC_PRIMARY && !clock_paused
        && (stat_q.startup_timer_done || !cfg.two_speed_startup_config);
    assign stable_bit = stat_q.fast_rc_stable;
    assign secondary_running = active_source == SRC_SECONDARY && !clock_paused;
    assign fast_rc_div_sel = freq_q;
    assign fast_rc_trim = trim_q;
    assign low_freq_source_select = lfsrc_q;
    assign multiplier_on = mult_q && mult_mode;
    assign watchdog_clk_from_low_rc = 1'b1;

    a_status_exclusive: assert property (@(posedge aclk) disable iff (!aresetn)
        !(startup_bit && secondary_running)) else $error("startup and secondary both set");
    a_mult_mode_only: assert property (@(posedge aclk) disable iff (!aresetn)
        !mult_mode |=> !mult_q && !multiplier_on) else $error("multiplier on outside mode");
    a_switch_pause: assert property (@(posedge aclk) disable iff (!aresetn)
        (sw_q == SW_RUN && target_src != active_source) |=> clock_paused [*6] ##1 !clock_paused)
        else $error("switch pause wrong length");
    a_freq_write: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_ctrl |=> fast_rc_div_sel == $past(wdata_q[FREQ_HI:FREQ_LO]))
        else $error("frequency not applied");

    // ************************************************************
    // axi4-lite read channel
    // ************************************************************
    logic [7:0] ctrl_rd;
    assign ctrl_rd = {idle_sel_q, freq_q, startup_bit, stable_bit, sel_q};
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr)
                OSC_CONTROL_ADDR: s_axi_rdata <= {24'h000000, ctrl_rd};
                OSC_TUNING_ADDR: s_axi_rdata <= {24'h000000, lfsrc_q, mult_q, trim_q};
                SLEEP_CTRL_ADDR: s_axi_rdata <= {30'h00000000, sleep_mode, idle_mode};
                CLOCK_STATUS_ADDR: s_axi_rdata <= {27'h0000000, multiplier_on,
                    clock_paused, secondary_running, active_source};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : scs_clock_select
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the clock select and tuning block
// assumes the package constants and the axi4-lite timing given by the designer
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import scs_pkg::*;
;
    // ****************************************
    // signals and design
    // ****************************************
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, sleep_exec = 1'b0;
    logic [1:0] bresp, rresp;
    scs_config_t cfg = {3'h4, 1'b1, 1'b0};
    scs_osc_stat_t osc_stat = {1'b1, 1'b1, 1'b0};
    scs_src_t active_source;
    logic [2:0] div_sel;
    logic [5:0] trim;
    logic lf_sel, mult_on, paused, sec_run, idle_m, sleep_m, wdt_lrc;
    int fails = 0, n_tests = 0, cyc = 0, run = 0, last_pause = 0;

    scs_clock_select i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .cfg(cfg), .osc_stat(osc_stat), .sleep_exec(sleep_exec),
        .active_source(active_source), .fast_rc_div_sel(div_sel), .fast_rc_trim(trim),
        .low_freq_source_select(lf_sel), .multiplier_on(mult_on), .clock_paused(paused),
        .secondary_running(sec_run), .idle_mode(idle_m), .sleep_mode(sleep_m),
        .watchdog_clk_from_low_rc(wdt_lrc));

    initial begin
        forever #20 aclk = ~aclk;
    end

    // pause length is measured here since it starts before the write task returns
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (paused === 1'b1) run <= run + 1;
        else if (run != 0) begin
            last_pause <= run;
            run <= 0;
        end
        if (cyc == 20000) begin
            fails = fails + 1;
            tally_and_finish();
        end
    end

    // ****************************************
    // bus and compare tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bit aw, w, b;
        int n;
        aw = 0; w = 0; b = 0; n = 0;
        awaddr <= a; wdata <= d; wstrb <= 4'hF;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!b && n < 50) begin
            @(posedge aclk);
            n++;
            if (!aw && awready === 1'b1) begin aw = 1; awvalid <= 1'b0; end
            if (!w && wready === 1'b1) begin w = 1; wvalid <= 1'b0; end
            if (aw && w && bvalid === 1'b1 && n > 1) begin
                b = 1;
                bready <= 1'b0;
                chk(bresp, (a[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR, "bresp");
            end
        end
        if (!b) chk(0, 1, "write hang");
        @(posedge aclk);
    endtask : wr

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
        bit ar, r;
        int n;
        ar = 0; r = 0; n = 0;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!r && n < 50) begin
            @(posedge aclk);
            n++;
            if (ar && rvalid === 1'b1) begin
                r = 1;
                rready <= 1'b0;
                chk(rdata, exp, what);
                chk(rresp, (a[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR, "rresp");
            end
            if (!ar && arready === 1'b1) begin ar = 1; arvalid <= 1'b0; end
        end
        if (!r) chk(0, 1, "read hang");
        @(posedge aclk);
    endtask : rd_chk

    // bounded wait for the source to settle, then a margin for the pause monitor
    task automatic wait_src(input scs_src_t s);
        int n;
        n = 0;
        while (!(active_source === s && paused === 1'b0) && n < 40) begin
            @(posedge aclk);
            n++;
        end
        repeat (2) @(posedge aclk);
        chk(active_source, s, "active source");
    endtask : wait_src

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        rd_chk(OSC_CONTROL_ADDR, 32'h48, "control reset");
        rd_chk(OSC_TUNING_ADDR, 32'h00, "tuning reset");
        chk(active_source, SRC_PRIMARY, "reset source");
        chk(wdt_lrc, 1'b1, "watchdog source");
        osc_stat.fast_rc_stable <= 1'b1;
        repeat (4) @(posedge aclk);
        rd_chk(OSC_CONTROL_ADDR, 32'h4C, "stable bit");
        cfg.two_speed_startup_config <= 1'b1;
        osc_stat.startup_timer_done <= 1'b0;
        repeat (4) @(posedge aclk);
        rd_chk(OSC_CONTROL_ADDR, 32'h44, "startup timer running");
        osc_stat.startup_timer_done <= 1'b1;
        repeat (4) @(posedge aclk);
        rd_chk(OSC_CONTROL_ADDR, 32'h4C, "startup timer done");
    endtask : t_reset

    task automatic t_switch();
        last_pause = 0;
        wr(OSC_CONTROL_ADDR, 32'h41);
        wait_src(SRC_SECONDARY);
        chk(last_pause, OLD_CYCLES + NEW_CYCLES, "pause length");
        chk(sec_run, 1'b1, "secondary running");
        rd_chk(CLOCK_STATUS_ADDR, 32'h05, "clock status secondary");
        rd_chk(OSC_CONTROL_ADDR, 32'h45, "startup bit clear");
        last_pause = 0;
        wr(OSC_CONTROL_ADDR, 32'h43);
        wait_src(SRC_FAST_RC);
        chk(last_pause, OLD_CYCLES + NEW_CYCLES, "pause to internal");
        chk(sec_run, 1'b0, "secondary stopped");
    endtask : t_switch

    task automatic t_freq();
        for (int c = 7; c >= 0; c--) begin
            wr(OSC_CONTROL_ADDR, {25'h0, c[2:0], 4'h3});
            chk(div_sel, c[2:0], "frequency select");
        end
        wait_src(SRC_LOW_RC);
        wr(OSC_TUNING_ADDR, 32'h80);
        wait_src(SRC_FAST_RC);
        chk(lf_sel, 1'b1, "low source select");
        wr(OSC_TUNING_ADDR, 32'h00);
        wr(OSC_CONTROL_ADDR, 32'h43);
        wait_src(SRC_FAST_RC);
    endtask : t_freq

    task automatic t_default();
        wr(OSC_CONTROL_ADDR, 32'h40);
        wait_src(SRC_PRIMARY);
        cfg.default_source_config_bit <= 1'b0;
        wr(OSC_CONTROL_ADDR, 32'h42);
        wr(OSC_CONTROL_ADDR, 32'h40);
        wait_src(SRC_FAST_RC);
        wr(OSC_CONTROL_ADDR, 32'h42);
        wait_src(SRC_PRIMARY);
        cfg.default_source_config_bit <= 1'b1;
    endtask : t_default

    task automatic t_mult();
        wr(OSC_TUNING_ADDR, 32'h7F);
        rd_chk(OSC_TUNING_ADDR, 32'h7F, "tuning readback");
        chk(trim, 6'h3F, "trim output");
        chk(mult_on, 1'b1, "multiplier crystal");
        rd_chk(CLOCK_STATUS_ADDR, 32'h10, "clock status multiplier");
        cfg.osc_mode <= MODE_EXT_MULT;
        repeat (2) @(posedge aclk);
        chk(mult_on, 1'b1, "multiplier external");
        cfg.osc_mode <= 3'h2;
        repeat (2) @(posedge aclk);
        chk(mult_on, 1'b0, "multiplier off");
        rd_chk(OSC_TUNING_ADDR, 32'h3F, "multiplier reads zero");
        wr(OSC_TUNING_ADDR, 32'h60);
        rd_chk(OSC_TUNING_ADDR, 32'h20, "multiplier write ignored");
        cfg.osc_mode <= MODE_XTAL_MULT;
        wr(OSC_TUNING_ADDR, 32'h00);
    endtask : t_mult

    task automatic t_sleep(input logic [31:0] ctl, input logic exp_i, input logic exp_s);
        wr(OSC_CONTROL_ADDR, ctl);
        sleep_exec <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(idle_m, exp_i, "idle mode");
        chk(sleep_m, exp_s, "sleep mode");
        rd_chk(SLEEP_CTRL_ADDR, {30'h0, exp_s, exp_i}, "sleep status");
        sleep_exec <= 1'b0;
        repeat (3) @(posedge aclk);
        chk({idle_m, sleep_m}, 2'b00, "awake");
    endtask : t_sleep

    task automatic t_misc();
        wr(4'h2, 32'h0000_00FF);
        rd_chk(4'h6, 32'h0000_0000, "unmapped read");
        rd_chk(OSC_CONTROL_ADDR, 32'h45, "unmapped write ignored");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(OSC_CONTROL_ADDR, 32'h4C, "control after reset");
        chk(active_source, SRC_PRIMARY, "source after reset");
    endtask : t_misc

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_switch();
        t_freq();
        t_default();
        t_mult();
        t_sleep(32'hC2, 1'b1, 1'b0);
        t_sleep(32'h42, 1'b0, 1'b1);
        osc_stat.secondary_osc_enable <= 1'b0;
        t_sleep(32'h41, 1'b0, 1'b0);
        t_misc();
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
